/* File: rdc_decoder.sv */
// Purpose: slave decoder for register write, extended write and register read sequences
// Assumes: bus clock and data pins are asynchronous and sampled by clk_in
// Notes:   data sampled on bus clock falling edges, read data driven on rising edges
// Function
// (R1) single register write accepted for any address zero to thirty-one
// (R2) address one lower index low byte; two to four index bit and A, B, C
// (R3) address five upper index low byte; six to eight index bit and D, E, F
// (R4) extended write count field is byte count minus one
// (R5) extended write starts at frame address and increments per byte up to top
// (R6) master updates A to C with four-byte extended write from address one
// (R7) master updates D to F with four-byte extended write from address five
// (R8) master may use one eight-byte or two four-byte extended writes
// (R9) status read returns zero top bit and seven error flags
// (R10) new A, B, C levels applied together when C register is written
// (R11) output-value writes ignored while enable bits for A, B, C are all clear
// (R12) odd parity checked per frame; failing write discarded and error flagged
module rdc_decoder (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  // slave identity
  input  wire logic [3:0]    usid_in,
  // serial bus pins
  input  wire logic          sclk_in,
  input  wire logic          sdata_in,
  output logic               sdata_out,
  output logic               sdata_oe_out,
  // register state
  output rdc_pkg::rdc_levels_t levels_out,
  output logic [6:0]         enable_out,
  output logic [6:0]         status_out
);

  logic [2:0]                        sclk_q;
  logic [2:0]                        sdata_q;
  logic [3:0]                        usid_q1;
  logic [3:0]                        usid_q2;
  logic                              sclk_fall;
  logic                              sclk_rise;
  logic                              clk_low;
  logic                              sd;
  logic                              ssc_start;
  logic                              reading;

  rdc_pkg::rdc_state_t               state;
  rdc_pkg::rdc_state_t               next_state;
  logic [3:0]                        cnt;
  logic [3:0]                        next_cnt;
  logic [11:0]                       sh;
  logic [11:0]                       next_sh;
  logic [7:0]                        addr;
  logic [7:0]                        next_addr;
  logic [3:0]                        left;
  logic [3:0]                        next_left;
  logic [8:0]                        rd_sh;
  logic [8:0]                        next_rd_sh;
  logic                              sd_o;
  logic                              next_sd_o;
  logic                              sd_oe;
  logic                              next_sd_oe;
  logic [rdc_pkg::REGS-1:0][7:0]     shadow;
  logic [rdc_pkg::REGS-1:0][7:0]     next_shadow;
  rdc_pkg::rdc_levels_t              levels;
  rdc_pkg::rdc_levels_t              next_levels;
  logic [6:0]                        status;
  logic [6:0]                        next_status;

  logic [12:0]                       frame;
  logic [4:0]                        rd_sel;
  logic [7:0]                        rd_byte;
  logic                              rd_unused;
  logic                              dac_ignore;
  logic                              sa_ok;
  logic                              cmd_done;
  logic                              rd_load;
  logic                              wr_fire;
  logic                              wr_apply;

  // pin synchronisers and edge finders
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sclk_q  <= 3'h0;
      sdata_q <= 3'h0;
      usid_q1 <= 4'h0;
      usid_q2 <= 4'h0;
    end else begin
      sclk_q  <= {sclk_q[1:0], sclk_in};
      sdata_q <= {sdata_q[1:0], sdata_in};
      usid_q1 <= usid_in;
      usid_q2 <= usid_q1;
    end
  end

  assign sclk_fall  = sclk_q[2] & ~sclk_q[1];
  assign sclk_rise  = ~sclk_q[2] & sclk_q[1];
  assign clk_low    = ~sclk_q[2] & ~sclk_q[1];
  assign sd         = sdata_q[1];
  // no start detection while the read turnaround owns the data line
  assign reading    = (state == rdc_pkg::ST_RPARK) || (state == rdc_pkg::ST_RDATA) || (state == rdc_pkg::ST_RPARK2);
  assign ssc_start  = ~sdata_q[2] & sdata_q[1] & clk_low & ~sd_oe & ~reading;
  assign frame      = {sh, sd};
  assign sa_ok      = (frame[12:9] == usid_q2) ||
                      ((frame[12:9] == rdc_pkg::BROADCAST_SA) && (frame[8:6] != rdc_pkg::OP_READ));
  assign dac_ignore = (shadow[rdc_pkg::REG_ENABLE][3:1] == 3'h0);
  assign cmd_done   = (state == rdc_pkg::ST_CMD) && sclk_fall && (cnt == rdc_pkg::CMD_LAST) && !ssc_start;

  // read data select
  always_comb begin
    rd_sel    = frame[5:1];
    rd_unused = 1'b0;
    if (rd_sel <= rdc_pkg::REG_LAST) begin
      rd_byte = shadow[rd_sel[3:0]];
    end else if (rd_sel == rdc_pkg::REG_STATUS) begin
      rd_byte = {1'b0, status}; // R9
    end else begin
      rd_byte   = 8'h00;
      rd_unused = 1'b1;
    end
  end

  // sequence decoder
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_sh     = sh;
    next_addr   = addr;
    next_left   = left;
    next_rd_sh  = rd_sh;
    next_sd_o   = sd_o;
    next_sd_oe  = sd_oe;
    next_shadow = shadow;
    next_levels = levels;
    next_status = status;
    rd_load     = 1'b0;
    wr_fire     = 1'b0;
    wr_apply    = 1'b0;
    if (ssc_start) begin
      if ((state == rdc_pkg::ST_CMD) || (state == rdc_pkg::ST_ADDR) || (state == rdc_pkg::ST_DATA)) begin
        next_status[rdc_pkg::ST_CMD_LEN] = 1'b1;
      end
      next_state = rdc_pkg::ST_SSC;
    end else begin
      case (state)
        rdc_pkg::ST_SSC: begin
          if (~sdata_q[1] & sdata_q[2] & clk_low) begin
            next_state = rdc_pkg::ST_CMD;
            next_cnt   = 4'h0;
          end else if (sclk_fall) begin
            next_state = rdc_pkg::ST_IDLE;
          end
        end
        rdc_pkg::ST_CMD: begin
          if (sclk_fall) begin
            next_sh  = frame[11:0];
            next_cnt = cnt + 4'h1;
            if (cnt == rdc_pkg::CMD_LAST) begin
              next_cnt = 4'h0;
              if (!sa_ok) begin
                next_state = rdc_pkg::ST_SKIP;
              end else if (^frame == 1'b0) begin
                next_status[rdc_pkg::ST_CMD_PAR] = 1'b1; // R12
                next_state = rdc_pkg::ST_SKIP;
              end else if (frame[8:6] == rdc_pkg::OP_WRITE) begin
                next_addr  = {3'h0, frame[5:1]}; // R1
                next_left  = 4'h0;
                next_state = rdc_pkg::ST_DATA;
              end else if (frame[8:6] == rdc_pkg::OP_READ) begin
                rd_load     = 1'b1;
                next_rd_sh  = {rd_byte, ~^rd_byte};
                next_status = 7'h00;
                next_status[rdc_pkg::ST_RD_UNUSED] = rd_unused;
                next_state  = rdc_pkg::ST_RPARK;
              end else if (frame[8:5] == rdc_pkg::OP_EXT) begin
                next_left  = frame[4:1]; // R4
                next_state = rdc_pkg::ST_ADDR;
              end else begin
                next_state = rdc_pkg::ST_SKIP;
              end
            end
          end
        end
        rdc_pkg::ST_ADDR: begin
          if (sclk_fall) begin
            next_sh  = frame[11:0];
            next_cnt = cnt + 4'h1;
            if (cnt == rdc_pkg::ADDR_LAST) begin
              next_cnt = 4'h0;
              if (^frame[8:0] == 1'b0) begin
                next_status[rdc_pkg::ST_ADDR_PAR] = 1'b1; // R12
                next_state = rdc_pkg::ST_SKIP;
              end else begin
                next_addr  = frame[8:1]; // R5
                next_state = rdc_pkg::ST_DATA;
              end
            end
          end
        end
        rdc_pkg::ST_DATA: begin
          if (sclk_fall) begin
            next_sh  = frame[11:0];
            next_cnt = cnt + 4'h1;
            if (cnt == rdc_pkg::DATA_LAST) begin
              next_cnt = 4'h0;
              if (^frame[8:0] == 1'b0) begin
                next_status[rdc_pkg::ST_DATA_PAR] = 1'b1; // R12
                next_state = rdc_pkg::ST_SKIP;
              end else begin
                wr_fire = 1'b1;
                if (addr <= {3'h0, rdc_pkg::REG_LAST}) begin
                  if (!dac_ignore || (addr == {3'h0, rdc_pkg::REG_ENABLE})) begin // R11
                    wr_apply = 1'b1;
                    next_shadow[addr[3:0]] = frame[8:1]; // R2 R3
                    if (addr == {3'h0, rdc_pkg::REG_ENABLE}) begin
                      next_shadow[addr[3:0]][7] = 1'b0;
                    end
                  end
                end else if (addr <= rdc_pkg::ADDR_TOP) begin
                  next_status[rdc_pkg::ST_WR_UNUSED] = 1'b1;
                end
                if (wr_apply && (addr == {3'h0, rdc_pkg::REG_C})) begin // R10
                  next_levels.lower_index = {next_shadow[rdc_pkg::REG_C][7], next_shadow[rdc_pkg::REG_B][7],
                                             next_shadow[rdc_pkg::REG_A][7], next_shadow[rdc_pkg::REG_LOWER_IDX]};
                  next_levels.a = next_shadow[rdc_pkg::REG_A][6:0];
                  next_levels.b = next_shadow[rdc_pkg::REG_B][6:0];
                  next_levels.c = next_shadow[rdc_pkg::REG_C][6:0];
                end
                if (wr_apply && (addr == {3'h0, rdc_pkg::REG_F})) begin
                  next_levels.upper_index = {next_shadow[rdc_pkg::REG_F][7], next_shadow[rdc_pkg::REG_E][7],
                                             next_shadow[rdc_pkg::REG_D][7], next_shadow[rdc_pkg::REG_UPPER_IDX]};
                  next_levels.d = next_shadow[rdc_pkg::REG_D][6:0];
                  next_levels.e = next_shadow[rdc_pkg::REG_E][6:0];
                  next_levels.f = next_shadow[rdc_pkg::REG_F][6:0];
                end
                if (left == 4'h0) begin
                  next_state = rdc_pkg::ST_IDLE;
                end else begin
                  next_left = left - 4'h1;
                  next_addr = addr + 8'h01; // R5
                end
              end
            end
          end
        end
        rdc_pkg::ST_RPARK: begin
          if (sclk_fall) begin
            next_state = rdc_pkg::ST_RDATA;
            next_cnt   = 4'h0;
          end
        end
        rdc_pkg::ST_RDATA: begin
          if (sclk_rise) begin
            next_sd_oe = 1'b1;
            next_cnt   = cnt + 4'h1;
            if (cnt == rdc_pkg::RD_LAST) begin
              next_sd_o  = 1'b0;
              next_state = rdc_pkg::ST_RPARK2;
            end else begin
              next_sd_o  = rd_sh[8]; // R9
              next_rd_sh = {rd_sh[7:0], 1'b0};
            end
          end
        end
        rdc_pkg::ST_RPARK2: begin
          if (sclk_fall) begin
            next_sd_oe = 1'b0;
            next_state = rdc_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
    next_status[rdc_pkg::ST_BUS_GRANT] = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state  <= rdc_pkg::ST_IDLE;
      cnt    <= 4'h0;
      sh     <= 12'h000;
      addr   <= 8'h00;
      left   <= 4'h0;
      rd_sh  <= 9'h000;
      sd_o   <= 1'b0;
      sd_oe  <= 1'b0;
      shadow <= rdc_pkg::SHADOW_RST;
      levels <= '0;
      status <= 7'h00;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      sh     <= next_sh;
      addr   <= next_addr;
      left   <= next_left;
      rd_sh  <= next_rd_sh;
      sd_o   <= next_sd_o;
      sd_oe  <= next_sd_oe;
      shadow <= next_shadow;
      levels <= next_levels;
      status <= next_status;
    end
  end

  assign sdata_out    = sd_o;
  assign sdata_oe_out = sd_oe;
  assign levels_out   = levels;
  assign enable_out   = shadow[rdc_pkg::REG_ENABLE][6:0];
  assign status_out   = status;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_read_cmd;
    rd_load;
  endsequence
  sequence s_park;
    (state == rdc_pkg::ST_RPARK) && !sd_oe;
  endsequence

  property p_write_any;
    (cmd_done && sa_ok && (^frame == 1'b1) && (frame[8:6] == rdc_pkg::OP_WRITE))
      |=> (state == rdc_pkg::ST_DATA) && (addr == {3'h0, $past(frame[5:1])}) && (left == 4'h0);
  endproperty
  a_write_any: assert property (p_write_any) else $error("register write not accepted"); // R1
  property p_lower_store;
    (wr_apply && (addr == {3'h0, rdc_pkg::REG_A})) |=> (shadow[rdc_pkg::REG_A] == $past(frame[8:1]));
  endproperty
  a_lower_store: assert property (p_lower_store) else $error("output a register not stored"); // R2
  property p_upper_apply;
    (wr_apply && (addr == {3'h0, rdc_pkg::REG_F}))
      |=> (levels.upper_index[7:0] == shadow[rdc_pkg::REG_UPPER_IDX]) && (levels.f == shadow[rdc_pkg::REG_F][6:0]);
  endproperty
  a_upper_apply: assert property (p_upper_apply) else $error("upper group not applied"); // R3
  property p_count;
    (cmd_done && sa_ok && (^frame == 1'b1) && (frame[8:5] == rdc_pkg::OP_EXT))
      |=> (left == $past(frame[4:1])) && (state == rdc_pkg::ST_ADDR);
  endproperty
  a_count: assert property (p_count) else $error("byte count not taken"); // R4
  property p_increment;
    (wr_fire && (left != 4'h0)) |=> (addr == $past(addr) + 8'h01) && (left == $past(left) - 4'h1);
  endproperty
  a_increment: assert property (p_increment) else $error("address not incremented"); // R5
  property p_read_park;
    s_read_cmd |=> s_park;
  endproperty
  a_read_park: assert property (p_read_park) else $error("read did not enter bus park"); // R9
  property p_status_top;
    (rd_load && (frame[5:1] == rdc_pkg::REG_STATUS)) |=> (rd_sh[8] == 1'b0) && (status == 7'h00);
  endproperty
  a_status_top: assert property (p_status_top) else $error("status read top bit set"); // R9
  property p_group_apply;
    (wr_apply && (addr == {3'h0, rdc_pkg::REG_C}))
      |=> (levels.a == shadow[rdc_pkg::REG_A][6:0]) && (levels.c == shadow[rdc_pkg::REG_C][6:0]);
  endproperty
  a_group_apply: assert property (p_group_apply) else $error("a to c not applied together"); // R10
  property p_ignore;
    dac_ignore |=> $stable(levels);
  endproperty
  a_ignore: assert property (p_ignore) else $error("levels changed while disabled"); // R11
  property p_parity_drop;
    ((state == rdc_pkg::ST_DATA) && sclk_fall && !ssc_start && (cnt == rdc_pkg::DATA_LAST) && (^frame[8:0] == 1'b0))
      |=> $stable(shadow) && status[rdc_pkg::ST_DATA_PAR] && (state == rdc_pkg::ST_SKIP);
  endproperty
  a_parity_drop: assert property (p_parity_drop) else $error("bad parity write not dropped"); // R12
endmodule

/* File: rdc_pkg.sv */
// Purpose: constants and types for the serial-bus register command decoder
// Assumes: odd parity on every frame, one data bit per bus clock
// Notes:   register indices equal the bus register addresses
package rdc_pkg;
  // frame lengths, last bit index counted from zero
  localparam logic [3:0] CMD_LAST  = 4'hc;
  localparam logic [3:0] ADDR_LAST = 4'h8;
  localparam logic [3:0] DATA_LAST = 4'h8;
  localparam logic [3:0] RD_LAST   = 4'h9;

  // register map
  localparam int unsigned REGS          = 9;
  localparam logic [4:0]  REG_ENABLE    = 5'h00;
  localparam logic [4:0]  REG_LOWER_IDX = 5'h01;
  localparam logic [4:0]  REG_A         = 5'h02;
  localparam logic [4:0]  REG_B         = 5'h03;
  localparam logic [4:0]  REG_C         = 5'h04;
  localparam logic [4:0]  REG_UPPER_IDX = 5'h05;
  localparam logic [4:0]  REG_D         = 5'h06;
  localparam logic [4:0]  REG_E         = 5'h07;
  localparam logic [4:0]  REG_F         = 5'h08;
  localparam logic [4:0]  REG_LAST      = 5'h08;
  localparam logic [4:0]  REG_STATUS    = 5'h1a;
  localparam logic [7:0]  ADDR_TOP      = 8'h1f;

  // reset values
  localparam logic [REGS-1:0][7:0] SHADOW_RST = {{8{8'h00}}, 8'h40};

  // command decode
  localparam logic [3:0] BROADCAST_SA = 4'h0;
  localparam logic [2:0] OP_WRITE     = 3'h2;
  localparam logic [2:0] OP_READ      = 3'h3;
  localparam logic [3:0] OP_EXT       = 4'h0;

  // status bit positions
  localparam int unsigned ST_CMD_PAR   = 6;
  localparam int unsigned ST_CMD_LEN   = 5;
  localparam int unsigned ST_ADDR_PAR  = 4;
  localparam int unsigned ST_DATA_PAR  = 3;
  localparam int unsigned ST_RD_UNUSED = 2;
  localparam int unsigned ST_WR_UNUSED = 1;
  localparam int unsigned ST_BUS_GRANT = 0;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SSC, ST_CMD, ST_ADDR, ST_DATA, ST_RPARK, ST_RDATA, ST_RPARK2, ST_SKIP
  } rdc_state_t;

  typedef struct packed {
    logic [10:0] lower_index;
    logic [6:0]  a;
    logic [6:0]  b;
    logic [6:0]  c;
    logic [10:0] upper_index;
    logic [6:0]  d;
    logic [6:0]  e;
    logic [6:0]  f;
  } rdc_levels_t;
endpackage

/* File: rdc_master_model.sv */
// Purpose: bus master model that drives write, extended write and read sequences
// Assumes: bus clock of 40 clk_in cycles, data set on rising and sampled on falling edges
// Notes:   holds data low while idle and releases it only for read data
module rdc_master_model (
  // clock
  input  wire logic clk_in,
  // resolved bus data
  input  wire logic line_in,
  // bus pins
  output logic      sclk_out,
  output logic      sdata_out,
  output logic      sdata_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 20;

  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    sdata_oe_out = 1'b1;
  end

  task automatic half_wait();
    repeat (HALF) @(posedge clk_in);
  endtask

  task automatic send_bit(input logic b);
    sclk_out <= 1'b1;
    sdata_out <= b;
    half_wait();
    sclk_out <= 1'b0;
    half_wait();
  endtask

  // odd parity over the frame, flip forces a bad one
  task automatic send_frame(input logic [11:0] v, input int n, input logic flip);
    for (int i = n - 1; i >= 0; i--) send_bit(v[i]);
    send_bit(~^v ^ flip);
  endtask

  // start condition: data rises then falls with the bus clock low
  task automatic ssc();
    @(posedge clk_in);
    sdata_out <= 1'b1;
    half_wait();
    sdata_out <= 1'b0;
    half_wait();
  endtask

  task automatic park();
    send_bit(1'b0);
    repeat (2 * HALF) @(posedge clk_in);
  endtask

  task automatic write_reg(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d, input logic [1:0] bad);
    ssc();
    send_frame({sa, 3'h2, a}, 12, bad[1]);
    send_frame({4'h0, d}, 8, bad[0]);
    park();
  endtask

  task automatic ext_write(input logic [3:0] sa, input logic [7:0] a, input logic [127:0] bytes, input int n);
    ssc();
    send_frame({sa, 4'h0, 4'(n - 1)}, 12, 1'b0);
    send_frame({4'h0, a}, 8, 1'b0);
    for (int i = 0; i < n; i++) send_frame({4'h0, bytes[127-8*i -: 8]}, 8, 1'b0);
    park();
  endtask

  // read: park clock, release, sample nine bits at falling edges, slave parks
  task automatic read_reg(input logic [3:0] sa, input logic [4:0] a, output logic [8:0] rd);
    ssc();
    send_frame({sa, 3'h3, a}, 12, 1'b0);
    sclk_out <= 1'b1;
    sdata_out <= 1'b0;
    half_wait();
    sclk_out <= 1'b0;
    sdata_oe_out <= 1'b0;
    half_wait();
    for (int i = 8; i >= 0; i--) begin
      sclk_out <= 1'b1;
      half_wait();
      rd[i] = line_in;
      sclk_out <= 1'b0;
      half_wait();
    end
    sclk_out <= 1'b1;
    half_wait();
    sclk_out <= 1'b0;
    sdata_oe_out <= 1'b1;
    half_wait();
    repeat (2 * HALF) @(posedge clk_in);
  endtask
endmodule

/* File: rdc_decoder_test.sv */
// Purpose: self-checking bench for the register command decoder
// Assumes: slave address 5, bus clock period 160 ns
// Notes:   undriven data line shows the inverse of its last driven level
module rdc_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] SA = 4'h5;
  localparam int LIMIT = 60000;
  logic                clk_in = 1'b0;
  logic                srst_in = 1'b1;
  logic [3:0]          usid_in = SA;
  logic                sclk, m_data, m_oe, line, dut_data, dut_oe;
  logic                last_line = 1'b0;
  rdc_pkg::rdc_levels_t lv;
  logic [6:0]          enable, status;
  logic [8:0]          r;
  int                  bad_count = 0;
  int                  checks_done = 0;
  int                  cycles = 0;

  always #2 clk_in = ~clk_in;
  assign line = dut_oe ? dut_data : (m_oe ? m_data : ~last_line);
  always @(posedge clk_in) begin
    if (dut_oe || m_oe) begin
      last_line <= line;
    end
  end

  rdc_decoder dut (.clk_in(clk_in), .srst_in(srst_in), .usid_in(usid_in), .sclk_in(sclk), .sdata_in(line),
    .sdata_out(dut_data), .sdata_oe_out(dut_oe), .levels_out(lv), .enable_out(enable), .status_out(status));
  rdc_master_model m (.clk_in(clk_in), .line_in(line), .sclk_out(sclk), .sdata_out(m_data), .sdata_oe_out(m_oe));

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] bad = 2'b00);
    m.write_reg(SA, a, d, bad);
  endtask

  task automatic t_single();
    check(enable, 16'h0040);
    wr(5'h00, 8'h0e);
    check(enable, 16'h000e);
    wr(5'h01, 8'h5a);
    wr(5'h02, 8'h81);
    check(lv.a, 16'h0000);
    wr(5'h03, 8'h02);
    wr(5'h04, 8'h83);
    check(lv.lower_index, 16'h055a);
    check({lv.a, lv.b, lv.c}, {2'b00, 7'h01, 7'h02, 7'h03});
  endtask

  task automatic t_quads();
    m.ext_write(SA, 8'h05, {8'h3c, 8'h85, 8'h06, 8'h87, 96'h0}, 4);
    check(lv.upper_index, 16'h053c);
    check({lv.d, lv.e, lv.f}, {2'b00, 7'h05, 7'h06, 7'h07});
    m.ext_write(SA, 8'h01, {8'h6b, 8'h08, 8'h89, 8'h0a, 96'h0}, 4);
    check(lv.lower_index, 16'h026b);
    check({lv.a, lv.b, lv.c}, {2'b00, 7'h08, 7'h09, 7'h0a});
  endtask

  task automatic t_eight();
    m.ext_write(SA, 8'h01, {64'h11921394_21a223a4, 64'h0}, 8);
    check(lv.lower_index, 16'h0511);
    check({lv.a, lv.c}, {2'b00, 7'h12, 7'h14});
    check(lv.upper_index, 16'h0521);
    check({lv.d, lv.f}, {2'b00, 7'h22, 7'h24});
  endtask

  task automatic t_count();
    m.ext_write(SA, 8'h00, {8'h0a, 120'h0}, 1);
    check(enable, 16'h000a);
    m.ext_write(SA, 8'h00, {72'h0e31b233b441c243c4, 56'hffffffffffffff}, 16);
    check(enable, 16'h000e);
    check(lv.upper_index, 16'h0541);
    check(lv.f, 16'h0044);
    check(status, 16'h0002);
  endtask

  task automatic t_status();
    m.read_reg(SA, 5'h1a, r);
    check(r, {7'h00, 8'h02, 1'b0});
    check(status, 16'h0000);
    wr(5'h1f, 8'h77);
    check(status, 16'h0002);
    m.read_reg(SA, 5'h10, r);
    check(r, {7'h00, 8'h00, 1'b1});
    m.read_reg(SA, 5'h1a, r);
    check(r, {7'h00, 8'h04, 1'b0});
  endtask

  task automatic t_parity();
    wr(5'h04, 8'h7f, 2'b01);
    check(lv.c, 16'h0034);
    wr(5'h04, 8'h7f, 2'b10);
    check(lv.c, 16'h0034);
    m.read_reg(SA, 5'h1a, r);
    check(r, {7'h00, 8'h48, 1'b1});
  endtask

  task automatic t_disabled();
    wr(5'h00, 8'h40);
    wr(5'h04, 8'h05);
    check(lv.c, 16'h0034);
    wr(5'h00, 8'h0e);
    wr(5'h04, 8'h05);
    check(lv.c, 16'h0005);
  endtask

  // foreign slave address ignored, broadcast write taken
  task automatic t_address();
    m.write_reg(4'h3, 5'h04, 8'h11, 2'b00);
    check(lv.c, 16'h0005);
    m.write_reg(4'h0, 5'h04, 8'h12, 2'b00);
    check(lv.c, 16'h0012);
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_single();
    t_quads();
    t_eight();
    t_count();
    t_status();
    t_parity();
    t_disabled();
    t_address();
    print_verdict();
  end
endmodule
